// File: core/bst_params.svh
// constants for the boundary-scan test port
// assumes inclusion by the test port package and modules
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
`define BST_IR_W        2
`define BST_OP_EXTEST   2'h0
`define BST_OP_SAMPLE   2'h1
`define BST_OP_IDCODE   2'h2
`define BST_OP_BYPASS   2'h3
`define BST_IR_CAPTURE  2'h1
`define BST_ID_W        32
`define BST_VER_W       3
`define BST_PART_W      16
`define BST_MFR_W       11
`define BST_ID_LSB      1'b1
// synchroniser lanes, in the order the pins are packed
`define BST_PIN_W       4
`define BST_PIN_TRST    3
`define BST_PIN_TCK     2
`define BST_PIN_TMS     1
`define BST_PIN_TDI     0
// arbitrary identity values, not those of any real part
`define BST_VER_DEF     3'h1
`define BST_PART_DEF    16'h0000
`define BST_MFR_DEF     11'h001
`endif

// File: core/bst_pkg.sv
// types for the boundary-scan test port
// assumes bst_params.svh is on the include path
`include "bst_params.svh"
package bst_pkg;
    typedef enum logic [3:0] {
        BST_RESET, BST_IDLE,
        BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR, BST_PAUSE_DR, BST_EXIT2_DR, BST_UPD_DR,
        BST_SEL_IR, BST_CAP_IR, BST_SHIFT_IR, BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
    } bst_state_e;
    typedef logic [`BST_IR_W-1:0] bst_ir_t;
endpackage

// File: core/bst_sync.sv
// two-flop synchroniser for test pins
// assumes inputs are asynchronous to clk
module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] q_d;
    always_comb
    begin
        s1_d = d;
        q_d  = s1_q;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= '0;
            q    <= '0;
        end
        else
        begin
            s1_q <= s1_d;
            q    <= q_d;
        end
    end
endmodule

// File: core/bst_tap.sv
// boundary-scan test access port: controller, instruction register, id and bypass
// assumes tck, tms, tdi, trst_n come from pins asynchronous to clk; tck much slower than clk
`include "bst_params.svh"
// Notes on behaviour
// - the port uses the five test pins trst_n, tck, tms, tdi and tdo.
// - the instruction is two bits; 10 selects identification and 11 selects bypass.
// - codes 01 (sample/preload) and 00 (external test) also select the one-bit bypass path.
// - under identification the id word is captured into the scan path and shifted out on tdo.
// - the id word is version, part number, manufacturer, then a fixed 1 in the lsb.
module bst_tap #(
    parameter logic [`BST_VER_W-1:0]  VERSION = `BST_VER_DEF,
    parameter logic [`BST_PART_W-1:0] PART    = `BST_PART_DEF,
    parameter logic [`BST_MFR_W-1:0]  MFR     = `BST_MFR_DEF
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          trst_n,
    input  wire logic          tck,
    input  wire logic          tms,
    input  wire logic          tdi,
    output logic               tdo,
    output logic               tdo_oe,
    output bst_pkg::bst_ir_t   instr
);
    import bst_pkg::*;
    // fields fill one bit short of the word; the spare msb is padded with zero on purpose
    localparam int ID_PAD_W = `BST_ID_W - `BST_VER_W - `BST_PART_W - `BST_MFR_W - 1;
    localparam logic [`BST_ID_W-1:0] ID_WORD = {{ID_PAD_W{1'b0}}, VERSION, PART, MFR, `BST_ID_LSB};

    logic [`BST_PIN_W-1:0] pin_s;
    logic                  trst_n_s;
    logic                  tck_s;
    logic                  tms_s;
    logic                  tdi_s;
    logic                  tck_q;
    logic                  tck_d;
    logic                  rise;
    logic                  fall;
    bst_state_e            state_q;
    bst_state_e            state_d;
    bst_ir_t               ir_sh_q;
    bst_ir_t               ir_sh_d;
    bst_ir_t               instr_d;
    logic [`BST_ID_W-1:0]  dr_q;
    logic [`BST_ID_W-1:0]  dr_d;
    logic                  tdo_d;
    logic                  tdo_oe_d;

    bst_sync #(
        .W (`BST_PIN_W)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({trst_n, tck, tms, tdi}),
        .q     (pin_s)
    );

    assign trst_n_s = pin_s[`BST_PIN_TRST];
    assign tck_s    = pin_s[`BST_PIN_TCK];
    assign tms_s    = pin_s[`BST_PIN_TMS];
    assign tdi_s    = pin_s[`BST_PIN_TDI];

    function automatic bst_state_e next_state(input bst_state_e s, input logic m);
        unique case (s)
            BST_RESET:    next_state = m ? BST_RESET  : BST_IDLE;
            BST_IDLE:     next_state = m ? BST_SEL_DR : BST_IDLE;
            BST_SEL_DR:   next_state = m ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR:   next_state = m ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_SHIFT_DR: next_state = m ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_EXIT1_DR: next_state = m ? BST_UPD_DR : BST_PAUSE_DR;
            BST_PAUSE_DR: next_state = m ? BST_EXIT2_DR : BST_PAUSE_DR;
            BST_EXIT2_DR: next_state = m ? BST_UPD_DR : BST_SHIFT_DR;
            BST_UPD_DR:   next_state = m ? BST_SEL_DR : BST_IDLE;
            BST_SEL_IR:   next_state = m ? BST_RESET  : BST_CAP_IR;
            BST_CAP_IR:   next_state = m ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_SHIFT_IR: next_state = m ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_EXIT1_IR: next_state = m ? BST_UPD_IR : BST_PAUSE_IR;
            BST_PAUSE_IR: next_state = m ? BST_EXIT2_IR : BST_PAUSE_IR;
            BST_EXIT2_IR: next_state = m ? BST_UPD_IR : BST_SHIFT_IR;
            BST_UPD_IR:   next_state = m ? BST_SEL_DR : BST_IDLE;
        endcase
    endfunction

    // every instruction but identification uses the one-bit bypass path
    function automatic logic is_idcode(input bst_ir_t i);
        is_idcode = (i == `BST_OP_IDCODE);
    endfunction

    // tck edges by oversampling; a phase shorter than one clk may be lost
    always_comb
    begin
        tck_d = tck_s;
        rise  = tck_s & ~tck_q;
        fall  = ~tck_s & tck_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            tck_q <= 1'b0;
        else
            tck_q <= tck_d;
    end

    always_comb
    begin
        state_d = state_q;
        if (!trst_n_s)
            state_d = BST_RESET;
        else if (rise)
            state_d = next_state(state_q, tms_s);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state_q <= BST_RESET;
        else
            state_q <= state_d;
    end

    always_comb
    begin
        ir_sh_d = ir_sh_q;
        if (trst_n_s && rise)
        begin
            if (state_q == BST_CAP_IR)
                ir_sh_d = `BST_IR_CAPTURE;
            else if (state_q == BST_SHIFT_IR)
                ir_sh_d = {tdi_s, ir_sh_q[`BST_IR_W-1:1]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ir_sh_q <= `BST_IR_CAPTURE;
        else
            ir_sh_q <= ir_sh_d;
    end

    always_comb
    begin
        instr_d = instr;
        if (!trst_n_s || state_q == BST_RESET)
            instr_d = `BST_OP_IDCODE;
        else if (rise && state_q == BST_UPD_IR)
            instr_d = ir_sh_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            instr <= `BST_OP_IDCODE;
        else
            instr <= instr_d;
    end

    always_comb
    begin
        dr_d = dr_q;
        if (trst_n_s && rise)
        begin
            if (state_q == BST_CAP_DR)
            begin
                if (is_idcode(instr))
                    dr_d = ID_WORD;
                else
                    dr_d = '0;
            end
            else if (state_q == BST_SHIFT_DR)
            begin
                if (is_idcode(instr))
                    dr_d = {tdi_s, dr_q[`BST_ID_W-1:1]};
                else
                    dr_d = {{(`BST_ID_W-1){1'b0}}, tdi_s};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            dr_q <= '0;
        else
            dr_q <= dr_d;
    end

    // tdo moves only after a falling tck, so the controller samples it settled at the rise
    always_comb
    begin
        tdo_d    = tdo;
        tdo_oe_d = tdo_oe;
        if (!trst_n_s)
            tdo_oe_d = 1'b0;
        else if (fall)
        begin
            tdo_oe_d = (state_q == BST_SHIFT_DR) || (state_q == BST_SHIFT_IR);
            if (state_q == BST_SHIFT_IR)
                tdo_d = ir_sh_q[0];
            else
                tdo_d = dr_q[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo    <= tdo_d;
            tdo_oe <= tdo_oe_d;
        end
    end
endmodule

// File: test/boundary_scan_test_port_bench.sv
// self-checking bench for the test port
// assumes bst_tap, its checker and the controller model
module boundary_scan_test_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             trst_n = 1'b1;
    logic             tck, tms, tdi, tdo, tdo_oe;
    bst_pkg::bst_ir_t instr;
    int               fail_count = 0;
    int               compares = 0;
    logic [31:0]      o;
    bst_ctl_model ctl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    bst_tap #(.VERSION(3'h5), .PART(16'h1234), .MFR(11'h2ab)) DUT (.clk(clk), .reset(reset),
        .trst_n(trst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .instr(instr));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // idle, go to shift, shift n bits lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] v);
        logic b;
        o = '0;
        ctl.step(1'b0, 1'b0, b);
        ctl.step(1'b1, 1'b0, b);
        if (ir)
            ctl.step(1'b1, 1'b0, b);
        ctl.step(1'b0, 1'b0, b);
        ctl.step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++)
        begin
            ctl.step(i == n - 1, v[i], b);
            o[i] = b;
        end
        ctl.step(1'b1, 1'b0, b);
        ctl.step(1'b0, 1'b0, b);
    endtask
    task automatic t_idcode;
        scan(1'b0, 32, 32'h0000_0000);
        chk(o, {1'b0, 3'h5, 16'h1234, 11'h2ab, 1'b1});
        $display("test idcode done");
    endtask
    task automatic t_codes;
        for (int c = 0; c < 4; c++)
        begin
            scan(1'b1, 2, 32'(c));
            chk(o, 32'h0000_0001);
            chk(instr, 32'(c));
            if (c != 2)
            begin
                scan(1'b0, 2, 32'h0000_0003);
                chk(o, 32'h0000_0002);
            end
        end
        $display("test codes done");
    endtask
    task automatic t_trst;
        @(posedge clk);
        trst_n <= 1'b0;
        repeat (7) @(posedge clk);
        #1 chk(instr, 32'h0000_0002);
        @(posedge clk);
        trst_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test trst done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_idcode();
        t_codes();
        t_trst();
        t_idcode();
        final_report();
    end
    // run needs about 23 us
    initial
    begin
        #100us;
        fail_count++;
        final_report();
    end
endmodule

// File: test/bst_ctl_model.sv
// stand-in for the external scan controller
// assumes the bench calls step; tck stands high between calls
module bst_ctl_model
(
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 170 ns tck period; tdo read just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        o = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// File: test/bst_tap_monitor.sv
// checker on the test port pins
// assumes bind onto bst_tap
module bst_mon
(
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             trst_n,
    input wire logic             tck,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire bst_pkg::bst_ir_t instr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_to_id: assert property ($fell(reset) |-> instr == 2'h2 && !tdo_oe)
        else $error("no idcode after reset");
    a_trst_forces: assert property (!trst_n [*6] |-> instr == 2'h2 && !tdo_oe)
        else $error("trst ignored");
    a_instr_idle: assert property ($changed(instr) |-> !tdo_oe)
        else $error("instr moved while shifting");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved with tck high");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
        else $error("tdo_oe moved with tck high");
    a_first_bit: assert property ($rose(tdo_oe) && instr == 2'h2 |-> tdo)
        else $error("first bit not 1");
    cover property (instr == 2'h3);
    cover property (instr == 2'h0 && tdo_oe);
    cover property ($fell(trst_n));
endmodule
bind bst_tap bst_mon u_mon (.clk(clk), .reset(reset), .trst_n(trst_n), .tck(tck), .tdo(tdo),
    .tdo_oe(tdo_oe), .instr(instr));
